/* core/spdc_top.sv */
// stepper phase decoder with per-bridge current chopper and apb registers
`timescale 1ns/1ns
`include "spdc_map.svh"
// Functional notes
// - inhibit low switches both bridges off
// - lowest select bit: two-phase or one-phase
// - three select bits become four half-bridge controls
// - codes 000 to 100 follow printed table
// - thermal shutdown with hysteresis disables both bridges
// - over-current flag resets the bridge latch
// - oscillator rising edge sets each latch
// - one common oscillator paces both choppers
// - only sink transistors chop, source stays on
// - reversal or shutdown uses fast decay
// - comparator input grounded while sink turns on
module spdc_top #(
  parameter int unsigned OSC_DIV   = `SPDC_OSC_DIV,
  parameter int unsigned BLANK_CYC = `SPDC_BLANK_CYC,
  parameter int unsigned DECAY_CYC = `SPDC_DECAY_CYC
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  // apb slave
  input  wire spdc_pkg::spdc_apb_req_t APB_REQ,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // step select and inhibit
  input  wire logic                  INH_N,
  input  wire logic                  STEP_SEL_MSB,
  input  wire logic                  STEP_SEL_MID,
  input  wire logic                  PHASE_COUNT_SEL,
  // oscillator, comparators, thermal sense
  input  wire logic                  OSC_EXT,
  input  wire logic [1:0]            OC_FLAG,
  input  wire logic                  THERM_HOT,
  input  wire logic                  THERM_COOL,
  // bridge drive, comparator blanking and interrupt
  output spdc_pkg::spdc_drive_t      WINDING_A_DRV,
  output spdc_pkg::spdc_drive_t      WINDING_B_DRV,
  output logic [1:0]                 CMP_BLANK,
  output logic                       IRQ
);
  import spdc_pkg::*;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic [1:0]  ctrl_q;
  logic [2:0]  sts_q;
  logic [2:0]  mask_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        irq_q;
  logic        tsd_q;
  logic [1:0]  lat_q;
  spdc_dir_t   app_q [2];

  // map: control at 0x00 (enable, oscillator source), status at 0x04 read-only,
  // event status at 0x08 (write one to clear), event mask at 0x0C;
  // unmapped offsets answer with pslverr and read as zero
  wire setup_ph  = APB_REQ.psel & ~APB_REQ.penable;
  wire access_wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & pready_q;
  wire hit_ctrl  = APB_REQ.paddr == `SPDC_OFF_CTRL;
  wire hit_stat  = APB_REQ.paddr == `SPDC_OFF_STATUS;
  wire hit_ists  = APB_REQ.paddr == `SPDC_OFF_IRQ_STS;
  wire hit_mask  = APB_REQ.paddr == `SPDC_OFF_IRQ_MASK;
  wire hit_any   = hit_ctrl | hit_stat | hit_ists | hit_mask;
  wire wr_ctrl   = access_wr & hit_ctrl;
  wire wr_ists   = access_wr & hit_ists;
  wire wr_mask   = access_wr & hit_mask;

  wire [31:0] status_w = {24'h0000_00, INH_N, tsd_q, lat_q,
                          app_q[1], app_q[0]};
  wire [31:0] rd_mux   = hit_ctrl ? {30'h0000_0000, ctrl_q}  :
                         hit_stat ? status_w                :
                         hit_ists ? {29'h0000_0000, sts_q}   :
                         hit_mask ? {29'h0000_0000, mask_q}  : 32'h0000_0000;

  // one setup cycle, answer in the first access cycle
  wire        pready_d  = setup_ph;
  wire        pslverr_d = setup_ph & ~hit_any;
  wire [31:0] prdata_d  = (setup_ph & ~APB_REQ.pwrite) ? rd_mux : 32'h0000_0000;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  wire [1:0] ctrl_d = wr_ctrl ? APB_REQ.pwdata[1:0] : ctrl_q;
  wire [2:0] mask_d = wr_mask ? APB_REQ.pwdata[2:0] : mask_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= `SPDC_CTRL_RST;
      mask_q <= `SPDC_MASK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------
  // common oscillator
  // ----------------------------------------
  logic [15:0] osc_cnt_q;
  logic        osc_int_q;
  logic        osc_prev_q;

  wire         osc_wrap  = osc_cnt_q == 16'(OSC_DIV - 1);
  wire [15:0]  osc_cnt_d = osc_wrap ? 16'h0000 : osc_cnt_q + 16'h0001;
  wire         osc_int_d = osc_cnt_q < 16'(OSC_DIV / 2);
  wire         osc_src   = ctrl_q[`SPDC_CTRL_OSC_EXT] ? OSC_EXT : osc_int_q;
  // one edge shared by both bridges keeps their chop periods aligned
  wire         osc_rise  = osc_src & ~osc_prev_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      osc_cnt_q  <= 16'h0000;
      osc_int_q  <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_cnt_q  <= osc_cnt_d;
      osc_int_q  <= osc_int_d;
      osc_prev_q <= osc_src;
    end
  end

  // ----------------------------------------
  // thermal shutdown and enable
  // ----------------------------------------
  // hot sets, only the cool flag (30 below trip) releases
  wire tsd_d     = THERM_HOT | (tsd_q & ~THERM_COOL);
  wire bridge_en = INH_N & ~tsd_q & ctrl_q[`SPDC_CTRL_EN];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tsd_q <= 1'b0;
    end else begin
      tsd_q <= tsd_d;
    end
  end

  // ----------------------------------------
  // step select decode
  // ----------------------------------------
  wire [2:0] step_sel = {STEP_SEL_MSB, STEP_SEL_MID, PHASE_COUNT_SEL};
  spdc_dir_t dec_dir [2];

  // odd codes leave one winding unpowered, even codes drive both
  always_comb begin
    unique case (step_sel)
      3'h0: begin
        dec_dir[0] = DIR_POS;
        dec_dir[1] = DIR_NEG;
      end
      3'h1: begin
        dec_dir[0] = DIR_POS;
        dec_dir[1] = DIR_OFF;
      end
      3'h2: begin
        dec_dir[0] = DIR_POS;
        dec_dir[1] = DIR_POS;
      end
      3'h3: begin
        dec_dir[0] = DIR_OFF;
        dec_dir[1] = DIR_POS;
      end
      3'h4: begin
        dec_dir[0] = DIR_NEG;
        dec_dir[1] = DIR_POS;
      end
      3'h5: begin
        dec_dir[0] = DIR_NEG;
        dec_dir[1] = DIR_OFF;
      end
      3'h6: begin
        dec_dir[0] = DIR_NEG;
        dec_dir[1] = DIR_NEG;
      end
      3'h7: begin
        dec_dir[0] = DIR_OFF;
        dec_dir[1] = DIR_NEG;
      end
    endcase
  end

  // ----------------------------------------
  // per-bridge chopper
  // ----------------------------------------
  spdc_drive_t drv_q   [2];
  logic [1:0]  blank_q;
  logic [1:0]  trip_ev;

  for (genvar i = 0; i < 2; i++) begin : g_bridge
    logic [15:0] dcy_q;
    logic [15:0] blk_q;
    spdc_dir_t   tgt;
    spdc_dir_t   app_d;
    spdc_drive_t drv_d;

    assign tgt = bridge_en ? dec_dir[i] : DIR_OFF;

    wire chg      = tgt != app_q[i];
    // any change away from a live direction first drops all four switches
    wire go_decay = chg & (app_q[i] != DIR_OFF);
    wire apply    = chg & (app_q[i] == DIR_OFF) & (dcy_q == 16'h0000);
    assign app_d  = go_decay ? DIR_OFF : (apply ? tgt : app_q[i]);

    // fixed dwell: a winding slower than the dwell may still carry current
    wire [15:0] dcy_d = go_decay ? 16'(DECAY_CYC) :
                        (dcy_q != 16'h0000) ? dcy_q - 16'h0001 : 16'h0000;

    // latch set on each rising oscillator edge or when a direction is applied
    wire set_l = (apply & (tgt != DIR_OFF)) |
                 (osc_rise & (app_q[i] != DIR_OFF) & ~go_decay);
    // flag ignored while blanked, so the turn-on spike cannot trip it
    wire clr_l = OC_FLAG[i] & (blk_q == 16'h0000);
    // set wins over a same-cycle reset
    wire lat_d = ~go_decay & (set_l | (lat_q[i] & ~clr_l));
    assign trip_ev[i] = lat_q[i] & clr_l & ~set_l & ~go_decay;

    wire [15:0] blk_d = set_l ? 16'(BLANK_CYC) :
                        (blk_q != 16'h0000) ? blk_q - 16'h0001 : 16'h0000;

    // source side holds on through the off part of the period
    always_comb begin
      drv_d = '0;
      unique case (app_d)
        DIR_POS: begin
          drv_d.src_p = 1'b1;
          drv_d.snk_n = lat_d;
        end
        DIR_NEG: begin
          drv_d.src_n = 1'b1;
          drv_d.snk_p = lat_d;
        end
        DIR_OFF: drv_d = '0;
      endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
        app_q[i]   <= DIR_OFF;
        dcy_q      <= 16'h0000;
        lat_q[i]   <= 1'b0;
        blk_q      <= 16'h0000;
        drv_q[i]   <= '0;
        blank_q[i] <= 1'b0;
      end else begin
        app_q[i]   <= app_d;
        dcy_q      <= dcy_d;
        lat_q[i]   <= lat_d;
        blk_q      <= blk_d;
        drv_q[i]   <= drv_d;
        blank_q[i] <= blk_d != 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [2:0] ev    = {trip_ev[1], trip_ev[0], tsd_d & ~tsd_q};
  wire [2:0] w1c   = wr_ists ? APB_REQ.pwdata[2:0] : 3'h0;
  // a new event outlives a clear written in the same cycle
  wire [2:0] sts_d = (sts_q & ~w1c) | ev;
  wire       irq_d = |(sts_d & mask_q);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sts_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign WINDING_A_DRV = drv_q[0];
  assign WINDING_B_DRV = drv_q[1];
  assign CMP_BLANK     = blank_q;
  assign IRQ           = irq_q;
endmodule : spdc_top

/* pkg/spdc_map.svh */
// spdc register offsets, fields, reset values and timing counts
`ifndef SPDC_MAP_SVH
`define SPDC_MAP_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SPDC_CLK_HZ        25000000
`define SPDC_OSC_HZ        60000
`define SPDC_OSC_DIV       (`SPDC_CLK_HZ / `SPDC_OSC_HZ)
`define SPDC_BLANK_NS      1000
`define SPDC_BLANK_CYC     ((`SPDC_BLANK_NS * (`SPDC_CLK_HZ / 1000000) + 999) / 1000)
`define SPDC_DECAY_NS      2000
`define SPDC_DECAY_CYC     ((`SPDC_DECAY_NS * (`SPDC_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPDC_OFF_CTRL      8'h00
`define SPDC_OFF_STATUS    8'h04
`define SPDC_OFF_IRQ_STS   8'h08
`define SPDC_OFF_IRQ_MASK  8'h0C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPDC_CTRL_EN       0
`define SPDC_CTRL_OSC_EXT  1
`define SPDC_CTRL_RST      2'h1
`define SPDC_EV_THERM      0
`define SPDC_EV_TRIP_A     1
`define SPDC_EV_TRIP_B     2
`define SPDC_EV_W          3
`define SPDC_MASK_RST      3'h0
`endif

/* pkg/spdc_pkg.sv */
// spdc shared types
package spdc_pkg;
  typedef enum logic [1:0] {DIR_OFF, DIR_POS, DIR_NEG} spdc_dir_t;
  typedef struct packed {
    logic src_p;
    logic snk_p;
    logic src_n;
    logic snk_n;
  } spdc_drive_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spdc_apb_req_t;
endpackage : spdc_pkg

/* verif/spdc_ctl_model.sv */
// controller-side model driving step select and inhibit
`timescale 1ns/1ns
module spdc_ctl_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // bench commands
  input  wire logic       step,
  input  wire logic       inh,
  // select and inhibit lines
  output logic            inh_n,
  output logic [2:0]      sel
);
  logic [2:0] pos_q;
  // half-step order; the even codes alone give full steps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pos_q <= 3'h0;
    else if (step) pos_q <= pos_q + 3'h1;
  end
  assign sel   = pos_q;
  assign inh_n = !inh;
endmodule : spdc_ctl_model

/* verif/spdc_top_sva.sv */
// port checker for the stepper decoder and chopper
`timescale 1ns/1ns
module spdc_top_sva (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    RESET,
  // register bus
  input wire spdc_pkg::spdc_apb_req_t APB_REQ,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  // bridge side
  input wire logic                    INH_N,
  input wire logic [1:0]              OC_FLAG,
  input wire logic                    THERM_HOT,
  input wire spdc_pkg::spdc_drive_t   WINDING_A_DRV,
  input wire spdc_pkg::spdc_drive_t   WINDING_B_DRV,
  input wire logic [1:0]              CMP_BLANK
);
  import spdc_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_setup;
    APB_REQ.psel && !APB_REQ.penable;
  endsequence
  sequence s_a_off3;
    (WINDING_A_DRV == 4'h0) [*3];
  endsequence
  a_pready_pulse: assert property (s_setup |=> PREADY ##1 !PREADY)
    else $error("pready not one pulse after setup");
  a_err_unmapped: assert property (PREADY && APB_REQ.paddr[1:0] == 2'h0 |->
    PSLVERR == (APB_REQ.paddr > 8'h0C)) else $error("pslverr wrong for address");
  a_inh_off: assert property ((!INH_N) [*3] |-> {WINDING_A_DRV, WINDING_B_DRV} == 8'h00)
    else $error("bridge driven while inhibited");
  a_therm_off: assert property (THERM_HOT [*3] |-> {WINDING_A_DRV, WINDING_B_DRV} == 8'h00)
    else $error("bridge driven while hot");
  a_fast_decay: assert property ($fell(WINDING_A_DRV.src_p) || $fell(WINDING_A_DRV.src_n) |->
    s_a_off3) else $error("no fast decay dwell");
  a_legal_drive: assert property (WINDING_A_DRV inside {4'h0, 4'h8, 4'h9, 4'h2, 4'h6} &&
    WINDING_B_DRV inside {4'h0, 4'h8, 4'h9, 4'h2, 4'h6}) else $error("illegal bridge state");
  a_oc_trip: assert property (WINDING_A_DRV.src_p && !CMP_BLANK[0] && OC_FLAG[0] |->
    ##[1:2] (!WINDING_A_DRV.snk_n || CMP_BLANK[0] || !WINDING_A_DRV.src_p))
    else $error("over-current did not cut sink");
  a_blank_on_set: assert property ($rose(WINDING_A_DRV.snk_n) |-> ##[0:1] CMP_BLANK[0])
    else $error("no blanking at sink turn-on");
  a_blank_len: assert property ($rose(CMP_BLANK[0]) |-> CMP_BLANK[0] [*2])
    else $error("blanking too short");
endmodule : spdc_top_sva

/* verif/spdc_top_tb.sv */
// self-checking bench for the stepper decoder and chopper
`timescale 1ns/1ns
module spdc_top_tb;
  import spdc_pkg::*;
  logic          clk, rst, osc, hot, cool, step, inh, inh_n, pready, pslverr, irq, er;
  logic [1:0]    oc, blank;
  logic [2:0]    sel;
  logic [31:0]   prdata, rd;
  spdc_apb_req_t req;
  spdc_drive_t   a_drv, b_drv;
  int            error_cnt, tests_run, cyc;
  // per code, two bits each: 0 off, 1 first-to-second, 2 reverse
  localparam logic [15:0] EXP_A = 16'h2A15;
  localparam logic [15:0] EXP_B = 16'hA152;
  spdc_ctl_model ctl (.clk(clk), .rst(rst), .step(step), .inh(inh), .inh_n(inh_n), .sel(sel));
  spdc_top #(.OSC_DIV(8), .BLANK_CYC(2), .DECAY_CYC(3)) dut (
    .CLK(clk), .RESET(rst), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INH_N(inh_n), .STEP_SEL_MSB(sel[2]), .STEP_SEL_MID(sel[1]), .PHASE_COUNT_SEL(sel[0]),
    .OSC_EXT(osc), .OC_FLAG(oc), .THERM_HOT(hot), .THERM_COOL(cool),
    .WINDING_A_DRV(a_drv), .WINDING_B_DRV(b_drv), .CMP_BLANK(blank), .IRQ(irq));
  task automatic results();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one transfer; waits for pready, never assumes a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc > 5000) begin
        error_cnt++;
        results();
      end
    end
  end
  initial begin
    {rst, inh} = 2'h3;
    {osc, hot, cool, step} = 4'h0;
    oc = 2'h0;
    req = '0;
    error_cnt = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h00, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h0C, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0003);
    rd_chk(8'h00, 32'h0000_0003);
    inh <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      tick(12);
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[3:0], {EXP_B[2*p+:2], EXP_A[2*p+:2]});
      chk(a_drv.src_p, EXP_A[2*p+:2] == 2'h1);
      step <= 1'b1;
      tick(1);
      step <= 1'b0;
    end
    tick(12);
    inh <= 1'b1;
    tick(3);
    chk({a_drv, b_drv}, 8'h00);
    inh <= 1'b0;
    apb(1'b1, 8'h0C, 32'h0000_0001);
    hot <= 1'b1;
    tick(5);
    chk({a_drv, b_drv, irq}, 9'h001);
    hot <= 1'b0;
    apb(1'b1, 8'h0C, 32'h0000_0000);
    tick(12);
    chk({a_drv, b_drv, irq}, 9'h000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd[7:6], 2'h3);
    rd_chk(8'h08, 32'h0000_0001);
    cool <= 1'b1;
    tick(12);
    chk({a_drv, b_drv}, 8'h96);
    cool <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0001);
    rd_chk(8'h08, 32'h0000_0000);
    apb(1'b1, 8'h0C, 32'h0000_0006);
    oc <= 2'h3;
    tick(1);
    oc <= 2'h0;
    tick(4);
    chk({a_drv, b_drv, irq}, 9'h105);
    rd_chk(8'h08, 32'h0000_0006);
    osc <= 1'b1;
    tick(1);
    oc <= 2'h3;
    tick(1);
    oc <= 2'h0;
    chk(blank, 2'h3);
    tick(4);
    chk({a_drv, b_drv}, 8'h96);
    osc <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0007);
    tick(3);
    chk(irq, 1'b0);
    oc <= 2'h3;
    tick(1);
    oc <= 2'h0;
    tick(2);
    chk({a_drv, b_drv}, 8'h82);
    rd_chk(8'h08, 32'h0000_0006);
    apb(1'b1, 8'h00, 32'h0000_0001);
    tick(12);
    chk({a_drv, b_drv}, 8'h96);
    apb(1'b1, 8'h00, 32'h0000_0000);
    tick(3);
    chk({a_drv, b_drv}, 8'h00);
    results();
  end
endmodule : spdc_top_tb
bind spdc_top spdc_top_sva u_sva (
  .CLK(CLK), .RESET(RESET), .APB_REQ(APB_REQ), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .INH_N(INH_N), .OC_FLAG(OC_FLAG), .THERM_HOT(THERM_HOT), .WINDING_A_DRV(WINDING_A_DRV),
  .WINDING_B_DRV(WINDING_B_DRV), .CMP_BLANK(CMP_BLANK));
